// file: rtl/pak_pkg.sv
// Package for the panel annunciator: constants, key codes, event bus types.
// Assumes one 20 MHz clock and AXI4-Lite register access.
package pak_pkg;
	localparam int unsigned CLK_HZ        = 20000000;
	localparam int unsigned SIL_LOCK_S    = 10;
	localparam int unsigned MENU_IDLE_S   = 60;
	localparam int unsigned SIL_LOCK_CYC  = SIL_LOCK_S * CLK_HZ;
	localparam int unsigned MENU_IDLE_CYC = MENU_IDLE_S * CLK_HZ;
	localparam int unsigned BLINK_CYC     = CLK_HZ / 2;
	localparam int unsigned NCLS          = 4;
	localparam int unsigned NSRC          = 8;

	// Event classes
	localparam logic [1:0] CLS_ALARM = 2'h0;
	localparam logic [1:0] CLS_PRE   = 2'h1;
	localparam logic [1:0] CLS_TRB   = 2'h2;
	localparam logic [1:0] CLS_SUP   = 2'h3;

	// Key codes, 0x0..0x9 are digits
	localparam logic [3:0] KEY_ACK   = 4'hA;
	localparam logic [3:0] KEY_SIL   = 4'hB;
	localparam logic [3:0] KEY_RST   = 4'hC;
	localparam logic [3:0] KEY_SCRL  = 4'hD;
	localparam logic [3:0] KEY_BKSP  = 4'hE;
	localparam logic [3:0] KEY_ENTER = 4'hF;
	localparam logic [3:0] KEY_MENU  = 4'h0;

	// Register byte addresses
	localparam logic [7:0] REG_CTRL   = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_LAMPS  = 8'h08;
	localparam logic [7:0] REG_VIEW   = 8'h0C;
	localparam logic [7:0] REG_ENTRY  = 8'h10;
	localparam logic [31:0] CTRL_RST  = 32'h0000_0000;

	// AXI responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Lamp drive
	typedef enum logic [1:0] {
		PAK_OFF    = 2'h0,
		PAK_STEADY = 2'h1,
		PAK_FLASH  = 2'h2
	} pak_lamp_t;

	// Event report from a field device or internal monitor
	typedef struct packed {
		logic       valid;
		logic [1:0] cls;
		logic [2:0] src;
		logic       on;
	} pak_evt_t;

	// Key press strobe
	typedef struct packed {
		logic       valid;
		logic [3:0] code;
	} pak_key_t;

	// Menu operation states
	typedef enum logic [1:0] {
		PAK_ST_IDLE = 2'b01,
		PAK_ST_MENU = 2'b10
	} pak_state_t;
endpackage

// file: rtl/pak_annunciator.sv
// Annunciator top: keys, event tracking, lamps, silence, menu timer.
// Assumes key and event strobes are synchronous one-cycle pulses on
// core_clk_i; mains_good_i comes from a pin and is synchronised here.
//
// Local design decisions: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/10ps
module pak_annunciator (
	input  wire logic              core_clk_i,
	input  wire logic              rst_n_i,
	input  wire pak_pkg::pak_key_t key_i,
	input  wire pak_pkg::pak_evt_t evt_i,
	input  wire logic              mains_good_i,
	input  wire logic [31:0]       s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [31:0]       s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	output logic                   lamp_power_o,
	output logic                   lamp_alarm_o,
	output logic                   lamp_pre_o,
	output logic                   lamp_trouble_o,
	output logic                   lamp_sup_o,
	output logic                   lamp_silence_o,
	output logic                   buzzer_o,
	output logic                   silenceable_en_o,
	output logic                   menu_active_o,
	output logic [3:0]             menu_key_o,
	output logic                   menu_key_vld_o
);
	localparam int NS = pak_pkg::NSRC;

	// Reset release through two flops
	logic rst_s1_q, rst_n_q;
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rst_s1_q <= 1'b0;
			rst_n_q  <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_n_q  <= rst_s1_q;
		end
	end

	// Mains-good pin synchroniser
	logic mains_s1_q, mains_q;
	always_ff @(posedge core_clk_i or negedge rst_n_q) begin
		if (!rst_n_q) begin
			mains_s1_q <= 1'b0;
			mains_q    <= 1'b0;
		end else begin
			mains_s1_q <= mains_good_i;
			mains_q    <= mains_s1_q;
		end
	end

	// Key decode
	logic k_ack, k_sil, k_rst, k_scrl, k_bksp, k_dig, k_ent;
	assign k_ack  = key_i.valid && key_i.code == pak_pkg::KEY_ACK;
	assign k_sil  = key_i.valid && key_i.code == pak_pkg::KEY_SIL;
	assign k_rst  = key_i.valid && key_i.code == pak_pkg::KEY_RST;
	assign k_scrl = key_i.valid && key_i.code == pak_pkg::KEY_SCRL;
	assign k_bksp = key_i.valid && key_i.code == pak_pkg::KEY_BKSP;
	assign k_ent  = key_i.valid && key_i.code == pak_pkg::KEY_ENTER;
	assign k_dig  = key_i.valid && key_i.code <= 4'h9;

	// Per class, per source: active, unacknowledged; per alarm source: off-report pending
	logic [NS-1:0] act_q   [pak_pkg::NCLS];
	logic [NS-1:0] unack_q [pak_pkg::NCLS];
	logic [NS-1:0] offpd_q;
	logic          alarm_latch_q;
	logic          all_acked, alarm_active, reset_ok, new_alarm;

	assign all_acked = (unack_q[0] | unack_q[1] | unack_q[2] | unack_q[3]
		| offpd_q) == '0;
	assign alarm_active = |act_q[pak_pkg::CLS_ALARM];
	assign reset_ok = k_rst && alarm_active == 1'b0
		&& unack_q[pak_pkg::CLS_ALARM] == '0 && offpd_q == '0;
	assign new_alarm = evt_i.valid && evt_i.on
		&& evt_i.cls == pak_pkg::CLS_ALARM;

	// Event tracking; a report arriving with an acknowledge is kept
	always_ff @(posedge core_clk_i or negedge rst_n_q) begin
		if (!rst_n_q) begin
			for (int c = 0; c < pak_pkg::NCLS; c++) begin
				act_q[c]   <= '0;
				unack_q[c] <= '0;
			end
			offpd_q       <= '0;
			alarm_latch_q <= 1'b0;
		end else begin
			if (k_ack) begin
				for (int c = 0; c < pak_pkg::NCLS; c++)
					unack_q[c] <= '0;
				offpd_q <= '0;
			end
			// A new alarm in the reset cycle keeps the lamp latched
			if (new_alarm)
				alarm_latch_q <= 1'b1;
			else if (reset_ok)
				alarm_latch_q <= 1'b0;
			if (evt_i.valid) begin
				act_q[evt_i.cls][evt_i.src] <= evt_i.on;
				if (evt_i.on)
					unack_q[evt_i.cls][evt_i.src] <= 1'b1;
				else if (evt_i.cls == pak_pkg::CLS_ALARM
					&& !unack_q[evt_i.cls][evt_i.src])
					offpd_q[evt_i.src] <= 1'b1;
			end
		end
	end

	// Shared blink generator
	logic [23:0] blink_cnt_q;
	logic        blink_q;
	always_ff @(posedge core_clk_i or negedge rst_n_q) begin
		if (!rst_n_q) begin
			blink_cnt_q <= '0;
			blink_q     <= 1'b0;
		end else if (blink_cnt_q == 24'(pak_pkg::BLINK_CYC - 1)) begin
			blink_cnt_q <= '0;
			blink_q     <= ~blink_q;
		end else begin
			blink_cnt_q <= blink_cnt_q + 24'h1;
		end
	end

	// Silence handling with lockout
	logic [27:0] sil_cnt_q;
	logic        sil_lock_q, silenced_q, sil_acc;
	assign sil_acc = k_sil && !sil_lock_q
		&& unack_q[pak_pkg::CLS_ALARM] == '0;
	always_ff @(posedge core_clk_i or negedge rst_n_q) begin
		if (!rst_n_q) begin
			sil_cnt_q  <= '0;
			sil_lock_q <= 1'b0;
		end else if (sil_acc) begin
			sil_cnt_q  <= 28'(pak_pkg::SIL_LOCK_CYC - 1);
			sil_lock_q <= 1'b1;
		end else if (sil_cnt_q != '0) begin
			sil_cnt_q <= sil_cnt_q - 28'h1;
		end else begin
			sil_lock_q <= 1'b0;
		end
	end
	always_ff @(posedge core_clk_i or negedge rst_n_q) begin
		if (!rst_n_q)
			silenced_q <= 1'b0;
		else if (reset_ok)
			silenced_q <= 1'b0;
		else if (sil_acc)
			silenced_q <= ~silenced_q;
	end

	// Menu operation, idle timer, scroll position and entry buffer
	pak_pkg::pak_state_t st_q;
	logic [30:0] idle_q;
	logic [2:0]  view_q;
	logic [15:0] entry_q;
	logic [2:0]  entry_n_q;
	always_ff @(posedge core_clk_i or negedge rst_n_q) begin
		if (!rst_n_q) begin
			st_q   <= pak_pkg::PAK_ST_IDLE;
			idle_q <= '0;
		end else begin
			unique case (st_q)
				pak_pkg::PAK_ST_IDLE: begin
					if (key_i.valid && key_i.code == pak_pkg::KEY_MENU
						&& !new_alarm) begin
						st_q   <= pak_pkg::PAK_ST_MENU;
						idle_q <= 31'(pak_pkg::MENU_IDLE_CYC - 1);
					end
				end
				pak_pkg::PAK_ST_MENU: begin
					if (new_alarm)
						st_q <= pak_pkg::PAK_ST_IDLE;
					else if (k_bksp && entry_n_q == '0)
						st_q <= pak_pkg::PAK_ST_IDLE;
					else if (key_i.valid)
						idle_q <= 31'(pak_pkg::MENU_IDLE_CYC - 1);
					else if (idle_q == '0)
						st_q <= pak_pkg::PAK_ST_IDLE;
					else
						idle_q <= idle_q - 31'h1;
				end
			endcase
		end
	end

	// Arrival order: older_q[i][j] is set when source i reported
	// before source j. A fresh on report makes its source the newest,
	// so scrolling outside the menu follows time of occurrence, not source number.
	logic [NS-1:0] older_q [NS];
	always_ff @(posedge core_clk_i or negedge rst_n_q) begin
		if (!rst_n_q) begin
			for (int i = 0; i < NS; i++)
				older_q[i] <= '0;
		end else if (evt_i.valid && evt_i.on) begin
			for (int i = 0; i < NS; i++)
				older_q[i][evt_i.src] <= 1'b1;
			older_q[evt_i.src] <= '0;
		end
	end

	// Scroll outside the menu: the oldest active source newer than the one on view;
	// past the newest it wraps round to the oldest active source
	logic [2:0]    nxt;
	logic          nxt_found, nxt_cand, old_cand;
	logic [NS-1:0] any_act;
	assign any_act = act_q[0] | act_q[1] | act_q[2] | act_q[3];
	always_comb begin
		nxt       = view_q;
		nxt_found = 1'b0;
		nxt_cand  = 1'b0;
		old_cand  = 1'b0;
		for (int j = 0; j < NS; j++) begin
			nxt_cand = any_act[j] && older_q[view_q][j];
			for (int k = 0; k < NS; k++)
				if (any_act[k] && older_q[view_q][k] && older_q[k][j])
					nxt_cand = 1'b0;
			if (nxt_cand && !nxt_found) begin
				nxt       = 3'(j);
				nxt_found = 1'b1;
			end
		end
		for (int j = 0; j < NS; j++) begin
			old_cand = any_act[j];
			for (int k = 0; k < NS; k++)
				if (any_act[k] && older_q[k][j])
					old_cand = 1'b0;
			if (old_cand && !nxt_found) begin
				nxt       = 3'(j);
				nxt_found = 1'b1;
			end
		end
	end
	always_ff @(posedge core_clk_i or negedge rst_n_q) begin
		if (!rst_n_q)
			view_q <= '0;
		else if (k_scrl && st_q == pak_pkg::PAK_ST_MENU)
			view_q <= view_q + 3'h1;
		else if (k_scrl)
			view_q <= nxt;
	end

	// Numeric entry buffer, backspace deletes the last digit
	always_ff @(posedge core_clk_i or negedge rst_n_q) begin
		if (!rst_n_q) begin
			entry_q   <= '0;
			entry_n_q <= '0;
		end else if (st_q != pak_pkg::PAK_ST_MENU || k_ent) begin
			entry_q   <= '0;
			entry_n_q <= '0;
		end else if (k_dig && entry_n_q != 3'h4) begin
			entry_q   <= {entry_q[11:0], key_i.code};
			entry_n_q <= entry_n_q + 3'h1;
		end else if (k_bksp && entry_n_q != '0) begin
			entry_q   <= {4'h0, entry_q[15:4]};
			entry_n_q <= entry_n_q - 3'h1;
		end
	end

	// Lamp state per class
	function automatic logic lamp(input logic [NS-1:0] u,
		input logic [NS-1:0] a, input logic b);
		lamp = (|u) ? b : (|a);
	endfunction

	// Registered outputs
	always_ff @(posedge core_clk_i or negedge rst_n_q) begin
		if (!rst_n_q) begin
			lamp_power_o     <= 1'b0;
			lamp_alarm_o     <= 1'b0;
			lamp_pre_o       <= 1'b0;
			lamp_trouble_o   <= 1'b0;
			lamp_sup_o       <= 1'b0;
			lamp_silence_o   <= 1'b0;
			buzzer_o         <= 1'b0;
			silenceable_en_o <= 1'b1;
			menu_active_o    <= 1'b0;
			menu_key_o       <= '0;
			menu_key_vld_o   <= 1'b0;
		end else begin
			lamp_power_o <= mains_q;
			lamp_alarm_o <= (|unack_q[0] || |offpd_q) ? blink_q
				: alarm_latch_q;
			lamp_pre_o     <= lamp(unack_q[1], act_q[1], blink_q);
			lamp_trouble_o <= lamp(unack_q[2], act_q[2], blink_q);
			lamp_sup_o     <= lamp(unack_q[3], act_q[3], blink_q);
			lamp_silence_o   <= silenced_q;
			buzzer_o         <= !all_acked;
			silenceable_en_o <= !silenced_q;
			menu_active_o    <= st_q == pak_pkg::PAK_ST_MENU;
			if (key_i.valid)
				menu_key_o <= key_i.code; // Holds the last key pressed
			menu_key_vld_o   <= key_i.valid
				&& st_q == pak_pkg::PAK_ST_MENU;
		end
	end

	// AXI4-Lite slave: one write and one read at a time
	logic        aw_q, w_q;
	logic [7:0]  awa_q;
	logic [31:0] wd_q, ctrl_q;
	always_ff @(posedge core_clk_i or negedge rst_n_q) begin
		if (!rst_n_q) begin
			aw_q <= 1'b0; w_q <= 1'b0; awa_q <= '0; wd_q <= '0;
			s_axi_awready <= 1'b1; s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0; s_axi_bresp <= pak_pkg::RESP_OKAY;
			ctrl_q <= pak_pkg::CTRL_RST;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_q <= 1'b1; awa_q <= s_axi_awaddr[7:0];
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_q <= 1'b1; wd_q <= s_axi_wdata;
				s_axi_wready <= 1'b0;
			end
			if (aw_q && w_q && !s_axi_bvalid) begin
				s_axi_bvalid <= 1'b1;
				aw_q <= 1'b0; w_q <= 1'b0;
				if (awa_q == pak_pkg::REG_CTRL) begin
					ctrl_q <= wd_q;
					s_axi_bresp <= pak_pkg::RESP_OKAY;
				end else if (awa_q == pak_pkg::REG_STATUS
					|| awa_q == pak_pkg::REG_LAMPS
					|| awa_q == pak_pkg::REG_VIEW
					|| awa_q == pak_pkg::REG_ENTRY)
					s_axi_bresp <= pak_pkg::RESP_OKAY;
				else
					s_axi_bresp <= pak_pkg::RESP_SLVERR;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1; s_axi_wready <= 1'b1;
			end
		end
	end

	// Read side; scratch control word is kept for software use
	always_ff @(posedge core_clk_i or negedge rst_n_q) begin
		if (!rst_n_q) begin
			s_axi_arready <= 1'b1; s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0; s_axi_rresp <= pak_pkg::RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rresp   <= pak_pkg::RESP_OKAY;
			unique case (s_axi_araddr[7:0])
				pak_pkg::REG_CTRL:   s_axi_rdata <= ctrl_q;
				pak_pkg::REG_STATUS: s_axi_rdata <= {24'h0, mains_q,
					sil_lock_q, silenced_q, st_q == pak_pkg::PAK_ST_MENU,
					alarm_latch_q, alarm_active, all_acked, !all_acked};
				pak_pkg::REG_LAMPS:  s_axi_rdata <= {25'h0, buzzer_o,
					lamp_silence_o, lamp_sup_o, lamp_trouble_o,
					lamp_pre_o, lamp_alarm_o, lamp_power_o};
				pak_pkg::REG_VIEW:   s_axi_rdata <= {29'h0, view_q};
				pak_pkg::REG_ENTRY:  s_axi_rdata <= {13'h0, entry_n_q,
					entry_q};
				default: begin
					s_axi_rdata <= '0;
					s_axi_rresp <= pak_pkg::RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end
endmodule

// file: verif/pak_annunciator_properties.sv
// Checker for the annunciator: port timing of keys, lamps and reads.
// Bound to pak_annunciator; sees its ports and nothing inside it.
`timescale 1ns/10ps
module pak_properties (
	input wire logic              core_clk_i,
	input wire logic              rst_n_i,
	input wire pak_pkg::pak_key_t key_i,
	input wire pak_pkg::pak_evt_t evt_i,
	input wire logic              mains_good_i,
	input wire logic              s_axi_arvalid,
	input wire logic              s_axi_arready,
	input wire logic              s_axi_rvalid,
	input wire logic              s_axi_rready,
	input wire logic [31:0]       s_axi_rdata,
	input wire logic              lamp_power_o,
	input wire logic              lamp_alarm_o,
	input wire logic              lamp_silence_o,
	input wire logic              buzzer_o,
	input wire logic              silenceable_en_o,
	input wire logic              menu_active_o
);
	logic sil_k;
	logic rst_k;
	logic ack_k;
	// Key decodes, each used by one property
	assign sil_k = key_i.valid && key_i.code == pak_pkg::KEY_SIL;
	assign rst_k = key_i.valid && key_i.code == pak_pkg::KEY_RST;
	assign ack_k = key_i.valid && key_i.code == pak_pkg::KEY_ACK;
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);
	// Alarm report once the internal reset copy has let go
	sequence s_alarm_on;
		$past(rst_n_i, 3) && evt_i.valid && evt_i.on && !key_i.valid
		&& evt_i.cls == pak_pkg::CLS_ALARM;
	endsequence
	// Acknowledge followed by three quiet cycles
	sequence s_ack_quiet;
		ack_k && !evt_i.valid ##1 !evt_i.valid [*3];
	endsequence
	a_power_follow: assert property (
		$stable(mains_good_i) [*8] |-> lamp_power_o == mains_good_i)
		else $error("power lamp does not follow mains");
	a_ack_mutes: assert property (s_ack_quiet |-> !buzzer_o)
		else $error("buzzer still on after acknowledge");
	a_alarm_buzz: assert property (s_alarm_on |-> ##2 buzzer_o)
		else $error("alarm report did not sound buzzer");
	a_menu_cancel: assert property (
		s_alarm_on |-> ##2 !menu_active_o)
		else $error("alarm did not cancel menu");
	a_sil_cause: assert property (
		$fell(silenceable_en_o) |-> $past(sil_k, 2))
		else $error("outputs silenced without silence key");
	a_sil_lamp: assert property (
		lamp_silence_o == !silenceable_en_o)
		else $error("silence lamp does not track outputs");
	a_alarm_dark: assert property (
		$fell(lamp_alarm_o) && !buzzer_o |-> $past(rst_k, 2))
		else $error("alarm lamp went dark without reset");
	a_read_resp: assert property (
		$past(rst_n_i, 3) && s_axi_arvalid && s_axi_arready
		|=> s_axi_rvalid)
		else $error("read answer late");
	a_rdata_hold: assert property (
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
		&& $stable(s_axi_rdata))
		else $error("read answer dropped before taken");
endmodule
bind pak_annunciator pak_properties pak_properties_i (
	.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .key_i(key_i),
	.evt_i(evt_i), .mains_good_i(mains_good_i),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.s_axi_rdata(s_axi_rdata), .lamp_power_o(lamp_power_o),
	.lamp_alarm_o(lamp_alarm_o), .lamp_silence_o(lamp_silence_o),
	.buzzer_o(buzzer_o), .silenceable_en_o(silenceable_en_o),
	.menu_active_o(menu_active_o)
);

// file: verif/pak_partner.sv
// Operator keypad and field event source model.
// Drives one-cycle strobes just after rising edges of clk_i.
`timescale 1ns/10ps
module pak_partner (
	input  wire logic         clk_i,
	output pak_pkg::pak_key_t key_o,
	output pak_pkg::pak_evt_t evt_o
);
	// Lines start at zero; after a strobe the idle lines carry the inverse payload so nothing stale looks valid
	initial begin
		key_o = '0;
		evt_o = '0;
	end
	// One press, then time for the registered outputs to settle
	task automatic press(input logic [3:0] c);
		@(posedge clk_i);
		key_o <= '{1'b1, c};
		@(posedge clk_i);
		key_o <= '{1'b0, ~c};
		repeat (3) @(posedge clk_i);
	endtask
	// One field report of class k from source s, on or off
	task automatic report(input logic [1:0] k, input logic [2:0] s,
		input logic o);
		@(posedge clk_i);
		evt_o <= '{1'b1, k, s, o};
		@(posedge clk_i);
		evt_o <= '{1'b0, ~k, ~s, ~o};
		repeat (3) @(posedge clk_i);
	endtask
endmodule

// file: verif/tb.sv
// Self-checking bench: keys, events, lamps and the register bus.
// Keys and events come from pak_partner; AXI4-Lite master tasks here.
`timescale 1ns/10ps
module tb;
	logic              clk;
	logic              rst_n;
	logic              mains;
	logic [31:0]       awaddr, wdata, araddr, rdata, d;
	logic              awvalid, wvalid, bready, arvalid, rready;
	logic              awready, wready, bvalid, arready, rvalid;
	logic [1:0]        bresp, rresp, r;
	logic              l_pwr, l_alm, l_pre, l_trb, l_sup, l_sil;
	logic              buzz, sil_en, menu;
	logic [3:0]        mkey, lamps;
	logic              mvld;
	pak_pkg::pak_key_t key;
	pak_pkg::pak_evt_t evt;
	int                bad_count = 0;
	int                num_checks = 0;
	int                vld_cnt = 0;
	assign lamps = {l_sup, l_trb, l_pre, l_alm};
	pak_annunciator pak_annunciator_i (
		.core_clk_i(clk), .rst_n_i(rst_n), .key_i(key), .evt_i(evt),
		.mains_good_i(mains), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.lamp_power_o(l_pwr), .lamp_alarm_o(l_alm), .lamp_pre_o(l_pre),
		.lamp_trouble_o(l_trb), .lamp_sup_o(l_sup),
		.lamp_silence_o(l_sil), .buzzer_o(buzz),
		.silenceable_en_o(sil_en), .menu_active_o(menu),
		.menu_key_o(mkey), .menu_key_vld_o(mvld)
	);
	pak_partner pak_partner_i (.clk_i(clk), .key_o(key), .evt_o(evt));
	// Count keys handed to the menu logic
	always @(posedge clk)
		if (mvld === 1'b1) vld_cnt <= vld_cnt + 1;
	// Case inequality so an unknown never counts as a match
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic end_of_test;
		if (bad_count == 0 && num_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	// Address and data offered together, each dropped once taken
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		awaddr <= {24'h000000, a};
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
		r = bresp;
		bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		araddr <= {24'h000000, a};
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	// The sequence needs a few hundred cycles; this cuts off a hang
	initial begin
		repeat (20000) @(posedge clk);
		bad_count++;
		end_of_test();
	end
	initial begin
		{rst_n, awvalid, wvalid, bready, arvalid, rready} = '0;
		{awaddr, wdata, araddr} = '0;
		mains = 1'b1;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		repeat (8) @(posedge clk);
		chk(l_pwr, 1'b1);
		chk({buzz, l_alm, sil_en}, 3'b001);
		mains <= 1'b0;
		repeat (8) @(posedge clk);
		chk(l_pwr, 1'b0);
		mains <= 1'b1;
		wr(pak_pkg::REG_CTRL, 32'hA5C3_0F12);
		chk(r, pak_pkg::RESP_OKAY);
		rd(pak_pkg::REG_CTRL);
		chk(d, 32'hA5C3_0F12);
		rd(8'h40);
		chk({r, d[29:0]}, {pak_pkg::RESP_SLVERR, 30'h0});
		wr(8'h40, 32'h0000_0001);
		chk(r, pak_pkg::RESP_SLVERR);
		pak_partner_i.press(pak_pkg::KEY_MENU);
		chk(menu, 1'b1);
		pak_partner_i.press(4'h5);
		chk(mkey, 4'h5);
		rd(pak_pkg::REG_ENTRY);
		chk(d, 32'h0001_0005);
		pak_partner_i.press(pak_pkg::KEY_ENTER);
		rd(pak_pkg::REG_ENTRY);
		chk(d, 32'h0000_0000);
		pak_partner_i.press(4'h7);
		pak_partner_i.press(pak_pkg::KEY_SCRL);
		rd(pak_pkg::REG_VIEW);
		chk(d, 32'h0000_0001);
		pak_partner_i.press(pak_pkg::KEY_BKSP);
		chk(menu, 1'b1);
		rd(pak_pkg::REG_ENTRY);
		chk(d, 32'h0000_0000);
		pak_partner_i.press(pak_pkg::KEY_BKSP);
		chk(menu, 1'b0);
		chk(vld_cnt, 32'h0000_0006);
		pak_partner_i.press(pak_pkg::KEY_MENU);
		pak_partner_i.report(pak_pkg::CLS_ALARM, 3'h1, 1'b1);
		chk({menu, buzz}, 2'b01);
		pak_partner_i.press(pak_pkg::KEY_SIL);
		chk({sil_en, l_sil}, 2'b10);
		pak_partner_i.press(pak_pkg::KEY_RST);
		chk(buzz, 1'b1);
		pak_partner_i.press(pak_pkg::KEY_ACK);
		chk({buzz, l_alm}, 2'b01);
		pak_partner_i.press(pak_pkg::KEY_RST);
		chk(l_alm, 1'b1);
		pak_partner_i.press(pak_pkg::KEY_SIL);
		chk({sil_en, l_sil}, 2'b01);
		pak_partner_i.press(pak_pkg::KEY_SIL);
		chk({sil_en, l_sil}, 2'b01);
		pak_partner_i.report(pak_pkg::CLS_ALARM, 3'h1, 1'b0);
		chk(buzz, 1'b1);
		pak_partner_i.press(pak_pkg::KEY_ACK);
		chk({buzz, l_alm}, 2'b01);
		pak_partner_i.press(pak_pkg::KEY_RST);
		chk({l_alm, l_sil, sil_en}, 3'b001);
		// Two sources per non-alarm class: the lamp stays lit until both report off
		for (int c = 1; c < 4; c++) begin
			// Higher source first, so arrival order differs from number
			pak_partner_i.report(c[1:0], 3'h3, 1'b1);
			pak_partner_i.report(c[1:0], 3'h2, 1'b1);
			chk(buzz, 1'b1);
			if (c == 1) begin
				pak_partner_i.press(pak_pkg::KEY_SCRL);
				rd(pak_pkg::REG_VIEW);
				chk(d, 32'h0000_0003);
				pak_partner_i.press(pak_pkg::KEY_SCRL);
				rd(pak_pkg::REG_VIEW);
				chk(d, 32'h0000_0002);
			end
			pak_partner_i.press(pak_pkg::KEY_ACK);
			chk({buzz, lamps[c]}, 2'b01);
			pak_partner_i.report(c[1:0], 3'h2, 1'b0);
			pak_partner_i.press(pak_pkg::KEY_ACK);
			chk(lamps[c], 1'b1);
			pak_partner_i.report(c[1:0], 3'h3, 1'b0);
			pak_partner_i.press(pak_pkg::KEY_ACK);
			chk(lamps[c], 1'b0);
		end
		// Reset in mid-run with an alarm standing clears all state
		pak_partner_i.report(pak_pkg::CLS_ALARM, 3'h4, 1'b1);
		chk(buzz, 1'b1);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		chk({buzz, l_alm, sil_en, menu}, 4'b0010);
		end_of_test();
	end
endmodule
